//--- src/linear_sensor_readout_sequencer.sv
// Readout and integration sequencer for a 32-pixel linear sensor, with sample FIFO
`timescale 1ns/100ps

module sample_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic full_reg;
  logic empty_reg;
  wire push = in_valid && !full_reg;
  wire pop = out_ready && !empty_reg;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      count_reg <= count_next;
      full_reg <= (count_next == (AW+1)'(DEPTH));
      empty_reg <= (count_next == '0);
    end
  end

  // Storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  assign in_ready = !full_reg;
  assign out_valid = !empty_reg;
  assign out_data = mem[rd_ptr_reg];
endmodule

// Contract
// - After reset discharge integration and hold capacitors; sample-and-hold in sample mode.
// - Start high at a rising sensor clock begins readout and new integration.
// - Main hold asserts at start; last-pixel hold asserts one clock later.
// - Readout of all pixels completes in exactly 32 clock pulses.
// - Integration reset low one period, between second and third falling edges.
// - Main hold drops after pixel 31 read; last hold drops one clock later.
// - Start before 32nd clock restarts at pixel 1, hold capacitors keep values.
// - Beyond 32 clocks without start, pixel 1 is routed without hold.
// - Shutter high disconnects photodiodes; integration voltages held.
// - Shutter low keeps integrating until next start.
// - Held pixel voltages go to analog output in order, one per clock.
module linear_sensor_readout_sequencer #(
  parameter int SAMPLE_WIDTH = sensor_seq_pkg::SAMPLE_W,
  parameter int DEPTH = sensor_seq_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Controller inputs, synchronous to REF_CLK
  input wire logic SENSOR_CLK,
  input wire logic START_INTEGRATION_IN,
  input wire logic SHUTTER_IN,
  // Pixel array control
  output logic HOLD_SELECT_MAIN,
  output logic HOLD_SELECT_LAST,
  output logic INTEG_CAP_RESET_N,
  output logic HOLD_CAP_DISCHARGE_N,
  output logic PHOTO_CONNECT,
  // Analogue output routing
  output logic [sensor_seq_pkg::PIX_IDX_W-1:0] ANALOG_OUT_SEL,
  output logic ANALOG_OUT_TRACK,
  output logic READOUT_ACTIVE,
  // Digitised level of analog_out
  input wire logic [SAMPLE_WIDTH-1:0] ANALOG_OUT_LEVEL,
  // Sample stream
  output logic SAMPLE_VALID,
  input wire logic SAMPLE_READY,
  output logic [sensor_seq_pkg::PIX_IDX_W+SAMPLE_WIDTH-1:0] SAMPLE_DATA,
  output logic BUFFER_READY,
  output logic SAMPLE_OVERRUN
);
  import sensor_seq_pkg::*;

  localparam int WORD_W = PIX_IDX_W + SAMPLE_WIDTH;

  seq_state_e state_reg;
  seq_state_e state_next;
  logic sclk_prev_reg;
  logic [PIX_IDX_W-1:0] pixel_reg;
  logic [PIX_IDX_W-1:0] pixel_next;
  logic hold_main_reg;
  logic hold_main_next;
  logic hold_last_reg;
  logic hold_last_next;
  logic cap_reset_n_reg;
  logic cap_reset_n_next;
  logic cap_reset_armed_reg;
  logic cap_reset_armed_next;
  logic hold_disch_n_reg;
  logic photo_connect_reg;
  logic overrun_reg;
  logic buf_ready_reg;
  logic track_reg;
  logic active_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;

  function automatic logic [PIX_IDX_W-1:0] pixel_after(input logic [PIX_IDX_W-1:0] p);
    pixel_after = p + 1'b1;
  endfunction

  // Edge detection on the controller clock
  wire sclk_rise = SENSOR_CLK && !sclk_prev_reg;
  wire sclk_fall = !SENSOR_CLK && sclk_prev_reg;
  wire start_seen = sclk_rise && START_INTEGRATION_IN;
  wire reading = (state_reg == ST_READ);
  wire restart = start_seen && reading && (pixel_reg != LAST_PIXEL);
  wire at_last = reading && (pixel_reg == LAST_PIXEL);

  // Sample of the pixel presently routed is taken as the index moves on
  wire push_valid = sclk_rise && reading && !restart;
  wire [WORD_W-1:0] push_word = {pixel_reg, ANALOG_OUT_LEVEL};
  wire overrun_event = push_valid && !fifo_in_ready;

  always_comb begin
    state_next = state_reg;
    pixel_next = pixel_reg;
    hold_main_next = hold_main_reg;
    hold_last_next = hold_last_reg;
    if (start_seen) begin
      state_next = ST_READ;
      pixel_next = FIRST_PIXEL;
      if (restart) begin
        // Capacitors already hold the earlier line; leave them held
        hold_main_next = hold_main_reg;
        hold_last_next = hold_last_reg;
      end else begin
        hold_main_next = 1'b1;
        hold_last_next = hold_last_reg;
      end
    end else if (sclk_rise) begin
      case (state_reg)
        ST_READ: begin
          if (pixel_reg == FIRST_PIXEL) begin
            hold_last_next = 1'b1;
          end
          if (at_last) begin
            // Clock 33 ends the run; last hold released a clock after main
            state_next = ST_TRACK;
            pixel_next = FIRST_PIXEL;
            hold_last_next = 1'b0;
          end else begin
            pixel_next = pixel_after(pixel_reg);
            if (pixel_after(pixel_reg) == LAST_PIXEL) begin
              hold_main_next = 1'b0;
            end
          end
        end
        ST_TRACK: begin
          pixel_next = FIRST_PIXEL;
        end
        default: begin
          pixel_next = NO_PIXEL;
        end
      endcase
    end
  end

  // Integration reset: armed at the second rising edge, low from fall 2 to fall 3
  always_comb begin
    cap_reset_n_next = cap_reset_n_reg;
    cap_reset_armed_next = cap_reset_armed_reg;
    if (sclk_rise && state_next == ST_READ && pixel_next == CAP_RESET_PIXEL) begin
      cap_reset_armed_next = 1'b1;
    end
    if (sclk_fall) begin
      if (cap_reset_armed_reg) begin
        cap_reset_n_next = 1'b0;
        cap_reset_armed_next = 1'b0;
      end else begin
        cap_reset_n_next = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
      sclk_prev_reg <= 1'b0;
      pixel_reg <= NO_PIXEL;
      track_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sclk_prev_reg <= SENSOR_CLK;
      pixel_reg <= pixel_next;
      // State flags registered so the pins carry no decode glitches
      track_reg <= (state_next == ST_TRACK);
      active_reg <= (state_next == ST_READ);
    end
  end

  // Reset values leave both capacitor banks discharged and in sample mode
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_main_reg <= HOLD_MAIN_RST;
      hold_last_reg <= HOLD_LAST_RST;
      cap_reset_n_reg <= CAP_RESET_N_RST;
      cap_reset_armed_reg <= 1'b0;
      hold_disch_n_reg <= HOLD_DISCH_N_RST;
    end else begin
      hold_main_reg <= hold_main_next;
      hold_last_reg <= hold_last_next;
      cap_reset_n_reg <= cap_reset_n_next;
      cap_reset_armed_reg <= cap_reset_armed_next;
      hold_disch_n_reg <= 1'b1;
    end
  end

  // Shutter gates the photodiode switch; held charge is untouched
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      photo_connect_reg <= PHOTO_CONNECT_RST;
    end else begin
      photo_connect_reg <= !SHUTTER_IN;
    end
  end

  // Overrun sticks until the next start; a new event wins over the clear
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      overrun_reg <= 1'b0;
      buf_ready_reg <= 1'b0;
    end else begin
      if (overrun_event) begin
        overrun_reg <= 1'b1;
      end else if (start_seen) begin
        overrun_reg <= 1'b0;
      end
      buf_ready_reg <= fifo_in_ready;
    end
  end

  // Sensor clock cannot be stalled, so a full buffer drops words and flags it
  sample_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(SAMPLE_READY),
    .out_data(fifo_out_data)
  );

  assign HOLD_SELECT_MAIN = hold_main_reg;
  assign HOLD_SELECT_LAST = hold_last_reg;
  assign INTEG_CAP_RESET_N = cap_reset_n_reg;
  assign HOLD_CAP_DISCHARGE_N = hold_disch_n_reg;
  assign PHOTO_CONNECT = photo_connect_reg;
  assign ANALOG_OUT_SEL = pixel_reg;
  assign ANALOG_OUT_TRACK = track_reg;
  assign READOUT_ACTIVE = active_reg;
  assign SAMPLE_VALID = fifo_out_valid;
  assign SAMPLE_DATA = fifo_out_data;
  assign BUFFER_READY = buf_ready_reg;
  assign SAMPLE_OVERRUN = overrun_reg;
endmodule

//--- inc/sensor_seq_pkg.sv
// Constants and types shared by the linear sensor readout sequencer
package sensor_seq_pkg;

  // Pixel line geometry
  localparam int NUM_PIXELS = 32;
  localparam int PIX_IDX_W = 6;
  localparam logic [5:0] FIRST_PIXEL = 6'h01;
  localparam logic [5:0] LAST_PIXEL = 6'h20;
  localparam logic [5:0] NO_PIXEL = 6'h00;

  // Pixel at whose rising edge the integration reset is armed
  localparam logic [5:0] CAP_RESET_PIXEL = 6'h02;

  // Sample word width and buffer depth defaults
  localparam int SAMPLE_W = 12;
  localparam int FIFO_DEPTH = 16;

  // Values after reset
  localparam logic HOLD_MAIN_RST = 1'b0;
  localparam logic HOLD_LAST_RST = 1'b0;
  localparam logic CAP_RESET_N_RST = 1'b0;
  localparam logic HOLD_DISCH_N_RST = 1'b0;
  localparam logic PHOTO_CONNECT_RST = 1'b0;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_TRACK = 2'b10
  } seq_state_e;

endpackage

//--- test/sensor_seq_assertions.sv
// Port timing checks for the readout sequencer
`timescale 1ns/100ps
module sensor_seq_checker
  import sensor_seq_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Controller lines
  input wire logic SENSOR_CLK,
  input wire logic START_INTEGRATION_IN,
  input wire logic SHUTTER_IN,
  // Array control and routing
  input wire logic HOLD_SELECT_MAIN,
  input wire logic HOLD_SELECT_LAST,
  input wire logic INTEG_CAP_RESET_N,
  input wire logic PHOTO_CONNECT,
  input wire logic [PIX_IDX_W-1:0] ANALOG_OUT_SEL,
  input wire logic ANALOG_OUT_TRACK,
  input wire logic READOUT_ACTIVE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  property p_start; $rose(SENSOR_CLK) && START_INTEGRATION_IN
    |=> ANALOG_OUT_SEL == FIRST_PIXEL && HOLD_SELECT_MAIN && READOUT_ACTIVE; endproperty
  a_start: assert property (p_start) else $error("start");
  property p_step; $rose(SENSOR_CLK) && !START_INTEGRATION_IN && READOUT_ACTIVE
    && ANALOG_OUT_SEL < LAST_PIXEL |=> ANALOG_OUT_SEL == $past(ANALOG_OUT_SEL) + 6'h01; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_end; $rose(SENSOR_CLK) && !START_INTEGRATION_IN && ANALOG_OUT_SEL == LAST_PIXEL
    |=> ANALOG_OUT_TRACK && !READOUT_ACTIVE && ANALOG_OUT_SEL == FIRST_PIXEL; endproperty
  a_end: assert property (p_end) else $error("end");
  property p_last_up; $rose(HOLD_SELECT_LAST) |-> HOLD_SELECT_MAIN && ANALOG_OUT_SEL == 6'h02;
  endproperty
  a_last_up: assert property (p_last_up) else $error("last up");
  property p_main_dn; $fell(HOLD_SELECT_MAIN) |-> ANALOG_OUT_SEL == LAST_PIXEL; endproperty
  a_main_dn: assert property (p_main_dn) else $error("main down");
  property p_last_dn; $fell(HOLD_SELECT_LAST) |-> ANALOG_OUT_SEL == FIRST_PIXEL; endproperty
  a_last_dn: assert property (p_last_dn) else $error("last down");
  property p_cap_dn; $fell(INTEG_CAP_RESET_N) |-> ANALOG_OUT_SEL == CAP_RESET_PIXEL; endproperty
  a_cap_dn: assert property (p_cap_dn) else $error("cap reset");
  property p_photo; $changed(SHUTTER_IN) |=> PHOTO_CONNECT == !$past(SHUTTER_IN); endproperty
  a_photo: assert property (p_photo) else $error("photo");
endmodule
bind linear_sensor_readout_sequencer sensor_seq_checker i_sensor_seq_checker (
  .REF_CLK(REF_CLK),
  .RESET_N(RESET_N),
  .SENSOR_CLK(SENSOR_CLK),
  .START_INTEGRATION_IN(START_INTEGRATION_IN),
  .SHUTTER_IN(SHUTTER_IN),
  .HOLD_SELECT_MAIN(HOLD_SELECT_MAIN),
  .HOLD_SELECT_LAST(HOLD_SELECT_LAST),
  .INTEG_CAP_RESET_N(INTEG_CAP_RESET_N),
  .PHOTO_CONNECT(PHOTO_CONNECT),
  .ANALOG_OUT_SEL(ANALOG_OUT_SEL),
  .ANALOG_OUT_TRACK(ANALOG_OUT_TRACK),
  .READOUT_ACTIVE(READOUT_ACTIVE)
);

//--- test/sensor_ctrl_model.sv
// Controller model: free-running sensor clock, start set at falls
`timescale 1ns/100ps
module sensor_ctrl_model #(parameter int HALF = 3) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Start request
  input wire logic go,
  // Lines to the sequencer
  output logic sclk,
  output logic start
);
  logic [3:0] cnt_reg;
  // Phases of HALF+1 cycles stay above the two-cycle minimum
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      sclk <= 1'b0;
      start <= 1'b0;
    end else if (cnt_reg == 4'(HALF)) begin
      cnt_reg <= 4'h0;
      sclk <= !sclk;
      if (sclk) start <= go;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

//--- test/linear_sensor_readout_sequencer_test.sv
// Self-checking bench for the readout sequencer
`timescale 1ns/100ps
module linear_sensor_readout_sequencer_test;
  import sensor_seq_pkg::*;
  logic REF_CLK = 0, RESET_N = 0, SHUTTER_IN = 0, SAMPLE_READY = 0, go = 0;
  logic SENSOR_CLK, START_INTEGRATION_IN, HOLD_SELECT_MAIN, HOLD_SELECT_LAST;
  logic INTEG_CAP_RESET_N, HOLD_CAP_DISCHARGE_N, PHOTO_CONNECT, ANALOG_OUT_TRACK;
  logic READOUT_ACTIVE, SAMPLE_VALID, BUFFER_READY, SAMPLE_OVERRUN;
  logic [5:0] ANALOG_OUT_SEL, base = 6'h00;
  logic [11:0] ANALOG_OUT_LEVEL = 12'h000;
  logic [17:0] SAMPLE_DATA;
  int n_errors = 0, num_checks = 0, r;
  initial forever #2.5 REF_CLK = ~REF_CLK;
  initial begin
    #100000;
    n_errors++;
    results();
  end
  sensor_ctrl_model i_sensor_ctrl_model (.clk(REF_CLK), .rst_n(RESET_N), .go(go),
    .sclk(SENSOR_CLK), .start(START_INTEGRATION_IN));
  linear_sensor_readout_sequencer i_linear_sensor_readout_sequencer (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .SENSOR_CLK(SENSOR_CLK),
    .START_INTEGRATION_IN(START_INTEGRATION_IN), .SHUTTER_IN(SHUTTER_IN),
    .HOLD_SELECT_MAIN(HOLD_SELECT_MAIN), .HOLD_SELECT_LAST(HOLD_SELECT_LAST),
    .INTEG_CAP_RESET_N(INTEG_CAP_RESET_N), .HOLD_CAP_DISCHARGE_N(HOLD_CAP_DISCHARGE_N),
    .PHOTO_CONNECT(PHOTO_CONNECT), .ANALOG_OUT_SEL(ANALOG_OUT_SEL),
    .ANALOG_OUT_TRACK(ANALOG_OUT_TRACK), .READOUT_ACTIVE(READOUT_ACTIVE),
    .ANALOG_OUT_LEVEL(ANALOG_OUT_LEVEL), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_READY(SAMPLE_READY), .SAMPLE_DATA(SAMPLE_DATA),
    .BUFFER_READY(BUFFER_READY), .SAMPLE_OVERRUN(SAMPLE_OVERRUN));
  // Level carries the routed pixel, so every word names its source
  always @(posedge REF_CLK) ANALOG_OUT_LEVEL <= {base, ANALOG_OUT_SEL};
  task automatic chk_bit(string what, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic chk_vec(string what, logic [17:0] exp, logic [17:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Returns once the outputs answering a sensor edge have settled
  task automatic rise();
    @(posedge SENSOR_CLK);
    @(posedge REF_CLK) go <= 1'b0;
    @(posedge REF_CLK);
    #1;
  endtask
  task automatic fall();
    @(negedge SENSOR_CLK);
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask
  // n rises after a start; lh is the pixel-32 hold at rise 1, again arms a start for the next run
  task automatic run(int n, logic lh, logic again);
    for (int k = 1; k <= n; k++) begin
      rise();
      chk_vec("sel", 18'((k > 32) ? 1 : k), 18'(ANALOG_OUT_SEL));
      chk_bit("main", k < 32, HOLD_SELECT_MAIN);
      chk_bit("last", (k > 1 && k < 33) || (k == 1 && lh), HOLD_SELECT_LAST);
      chk_bit("track", k > 32, ANALOG_OUT_TRACK);
      chk_bit("active", k < 33, READOUT_ACTIVE);
      chk_bit("photo", !SHUTTER_IN, PHOTO_CONNECT);
      if (k == n && again) @(posedge REF_CLK) go <= 1'b1;
      fall();
      chk_bit("capreset", k != 2, INTEG_CAP_RESET_N);
      @(posedge REF_CLK) SHUTTER_IN <= 1'($urandom);
    end
  endtask
  initial begin
    void'($urandom(32'hc6be));
    base = 6'($urandom);
    r = 3 + $urandom % 28;
    @(posedge REF_CLK) #1;
    chk_bit("main", 0, HOLD_SELECT_MAIN);
    chk_bit("capreset", 0, INTEG_CAP_RESET_N);
    chk_bit("holdcap", 0, HOLD_CAP_DISCHARGE_N);
    repeat (2) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    rise();
    chk_bit("holdcap", 1, HOLD_CAP_DISCHARGE_N);
    chk_bit("last", 0, HOLD_SELECT_LAST);
    @(posedge REF_CLK) go <= 1'b1;
    run(34, 0, 0);
    #1;
    chk_bit("bufready", 0, BUFFER_READY);
    chk_bit("overrun", 1, SAMPLE_OVERRUN);
    @(posedge REF_CLK) SAMPLE_READY <= 1'b1;
    for (int i = 1; i <= 16; i++) begin
      #1;
      chk_bit("valid", 1, SAMPLE_VALID);
      chk_vec("data", {6'(i), base, 6'(i)}, SAMPLE_DATA);
      @(posedge REF_CLK);
    end
    #1;
    chk_bit("valid", 0, SAMPLE_VALID);
    chk_bit("bufready", 1, BUFFER_READY);
    @(posedge REF_CLK) go <= 1'b1;
    run(r, 0, 1);
    // Restart mid-line, then a start at pixel 32 which is a fresh start
    run(32, 1, 1);
    run(34, 1, 0);
    chk_bit("overrun", 0, SAMPLE_OVERRUN);
    results();
  end
endmodule
